/* File: pack_mux_pkg.sv */
package pack_mux_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] PACK_CFG_OFS = 8'h00;
   localparam logic [7:0] SCAN_CTRL_OFS = 8'h04;
   localparam logic [7:0] ALERT_STATUS_OFS = 8'h08;
   localparam logic [7:0] ALERT_MASK_OFS = 8'h0C;
   localparam logic [7:0] MUX_STATE_OFS = 8'h10;

   // -----------------------------------------------------------------
   // pack configuration field positions
   // -----------------------------------------------------------------
   localparam int TAP_A_LSB = 0;
   localparam int TAP_B_LSB = 4;
   localparam int BLOCK_TAP_LSB = 8;
   localparam int ENABLE_A_BIT = 12;
   localparam int ENABLE_B_BIT = 13;
   localparam int SCAN_DISCONNECT_BIT = 0;

   // status bits
   localparam int RESET_ALERT_BIT = 0;
   localparam int SUPPLY_FAULT_BIT = 1;
   localparam int SETTLE_DONE_BIT = 2;

   // -----------------------------------------------------------------
   // reset values and codes
   // -----------------------------------------------------------------
   localparam logic [3:0] TAP_OFF = 4'hF;
   localparam logic [3:0] TAP_MIN_VALID = 4'h8;
   localparam logic [3:0] BLOCK_PIN_CODE = 4'hF;
   localparam logic [15:0] PACK_CFG_RESET = 16'h3FFF;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int SETTLE_US = 30;
   localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
   localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_CYCLES - 1);

   // applied configuration to the analog switches
   typedef struct packed {
      logic muxEnable;
      logic [3:0] supplyTap;
      logic [3:0] blockTap;
   } mux_ctrl_s;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b00,
      SC_SETTLE = 2'b01,
      SC_CONVERT = 2'b11
   } scan_state_e;
endpackage

/* File: flexible_pack_power_mux_control.sv */
`timescale 1ns/1ns
// Overview of operation
// - after reset both pack mux enable bits read as one.
// - supply tap codes 0x0 to 0x7 and 0xF select the off position, also the reset value.
// - if the duplicated enables or taps disagree, the reset defaults are applied instead.
// - the block divider leaves its own pin only once taps are valid and enables set.
// - block tap picks the divider pin, 0xF is the block pin, codes 0x0 to 0x7 map to 0xF.
// - with valid taps, enables and scan disconnect set, the tap opens and 30 us pass before the top conversion.
// - scan disconnect acts only on alternate path acquisitions.
// - a supply power-on reset restores the enable bits to their reset state.
// - the supply mux fault flag rises when the enabled tap switch misbehaves.
// - the fault flag is held off after power-up until the reset alert is cleared.
// - all configuration, enable and alert registers are 16 bits wide.
module flexible_pack_power_mux_control
   import pack_mux_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // acquisition sequencer
   input wire logic topConvRequest,
   input wire logic altPathSelect,
   output logic topConvGo,
   // analog switch control and feedback
   input wire logic supplyTapSwitchOk,
   output mux_ctrl_s muxCtrl,
   output logic supplyTapSwitchOpen,
   // interrupt
   output logic irq
);

   // -----------------------------------------------------------------
   // reset synchroniser
   // -----------------------------------------------------------------
   logic rstMeta;
   logic rstSync;

   // two stage release of the async reset
   // every other process resets from rstSync, not the pin
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // supply tap: low half and 0xF are off
   function automatic logic [3:0] mapSupplyTap(input logic [3:0] code);
      mapSupplyTap = (code < TAP_MIN_VALID) ? TAP_OFF : code;
   endfunction

   // block tap: low half maps to the block pin
   function automatic logic [3:0] mapBlockTap(input logic [3:0] code);
      mapBlockTap = (code < TAP_MIN_VALID) ? BLOCK_PIN_CODE : code;
   endfunction

   // byte lane merge into a 16-bit register
   // only the two low strobes matter, the upper half is unused
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = data[15:8];
      end
   endfunction

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [15:0] pack_configuration_reg;
   logic [15:0] scanCtrl;
   logic [15:0] alertMask;
   logic resetAlertFlag;
   logic supplyMuxFaultFlag;
   logic settleDoneFlag;
   scan_state_e scanState;
   scan_state_e next_scanState;
   logic [10:0] settleCount;

   // -----------------------------------------------------------------
   // axi4-lite write path
   // -----------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic writeFire;

   // readies drop while a channel is held or a response waits
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign writeFire = awHeld && wHeld && !s_axi_bvalid;

   // capture address and data in either order
   // each channel drops its ready once held, until the write executes
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end else if (writeFire) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (writeFire) begin
            wHeld <= 1'b0;
         end
      end
   end

   // write response
   // error response for unmapped or unaligned offsets
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (writeFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awAddr <= MUX_STATE_OFS && awAddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // configuration registers
   // unused bits are masked so they always read zero
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         pack_configuration_reg <= PACK_CFG_RESET;
         scanCtrl <= 16'h0000;
         alertMask <= MASK_RESET;
      end else if (writeFire) begin
         unique case (awAddr)
            PACK_CFG_OFS: begin
               pack_configuration_reg <= merge16(pack_configuration_reg, wData, wStrb) & 16'h3FFF;
            end
            SCAN_CTRL_OFS: begin
               scanCtrl <= merge16(scanCtrl, wData, wStrb) & 16'h0001;
            end
            ALERT_MASK_OFS: begin
               alertMask <= merge16(alertMask, wData, wStrb) & 16'h0007;
            end
            default: begin
               // state word is read-only, status clears elsewhere
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // applied mux configuration
   // -----------------------------------------------------------------
   logic enA;
   logic enB;
   logic [3:0] tapA;
   logic [3:0] tapB;
   logic cfgAgree;
   logic packActive;
   logic [3:0] appliedTap;

   // decode both copies, fall back to defaults when they differ
   assign enA = pack_configuration_reg[ENABLE_A_BIT];
   assign enB = pack_configuration_reg[ENABLE_B_BIT];
   assign tapA = mapSupplyTap(pack_configuration_reg[TAP_A_LSB +: 4]);
   assign tapB = mapSupplyTap(pack_configuration_reg[TAP_B_LSB +: 4]);
   assign cfgAgree = (enA == enB) && (tapA == tapB);
   assign appliedTap = cfgAgree ? tapA : TAP_OFF;
   assign packActive = cfgAgree && enA && (appliedTap != TAP_OFF);

   // switch drive from flops
   // tap opens only for the settle span, never in the go cycle
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         muxCtrl <= '{muxEnable: 1'b1, supplyTap: TAP_OFF, blockTap: BLOCK_PIN_CODE};
         supplyTapSwitchOpen <= 1'b0;
      end else begin
         muxCtrl.muxEnable <= cfgAgree ? enA : 1'b1;
         muxCtrl.supplyTap <= appliedTap;
         muxCtrl.blockTap <= packActive ? mapBlockTap(pack_configuration_reg[BLOCK_TAP_LSB +: 4])
                                        : BLOCK_PIN_CODE;
         supplyTapSwitchOpen <= (next_scanState == SC_SETTLE);
      end
   end

   // -----------------------------------------------------------------
   // scan disconnect sequencer
   // -----------------------------------------------------------------
   // next state
   // requests outside idle are ignored
   always_comb begin
      next_scanState = scanState;
      unique case (scanState)
         SC_IDLE: begin
            if (topConvRequest) begin
               if (packActive && scanCtrl[SCAN_DISCONNECT_BIT] && altPathSelect) begin
                  next_scanState = SC_SETTLE;
               end else begin
                  next_scanState = SC_CONVERT;
               end
            end
         end
         SC_SETTLE: begin
            if (settleCount == SETTLE_LAST) begin
               next_scanState = SC_CONVERT;
            end
         end
         SC_CONVERT: begin
            next_scanState = SC_IDLE;
         end
         default: begin
            next_scanState = SC_IDLE;
         end
      endcase
   end

   // state and settle counter
   // counter runs 0 to SETTLE_LAST, so the tap stays open SETTLE_CYCLES
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         scanState <= SC_IDLE;
         settleCount <= 11'd0;
      end else begin
         scanState <= next_scanState;
         settleCount <= (scanState == SC_SETTLE) ? settleCount + 11'd1 : 11'd0;
      end
   end

   // one-cycle go straight from the state register
   assign topConvGo = (scanState == SC_CONVERT);

   // -----------------------------------------------------------------
   // alert status
   // -----------------------------------------------------------------
   logic clrWrite;
   logic [15:0] clrBits;
   logic settleEvent;
   logic faultEvent;

   // write-one-to-clear strobes and set events
   assign clrWrite = writeFire && (awAddr == ALERT_STATUS_OFS);
   assign clrBits = clrWrite ? merge16(16'h0000, wData, wStrb) : 16'h0000;
   assign settleEvent = (scanState == SC_SETTLE) && (settleCount == SETTLE_LAST);
   // fault only while the tap is meant to conduct, gated by reset alert
   assign faultEvent = packActive && !supplyTapSwitchOpen && !supplyTapSwitchOk
                       && !resetAlertFlag;

   // sticky bits, set wins over write-one clear
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         resetAlertFlag <= 1'b1;
         supplyMuxFaultFlag <= 1'b0;
         settleDoneFlag <= 1'b0;
      end else begin
         resetAlertFlag <= resetAlertFlag && !clrBits[RESET_ALERT_BIT];
         supplyMuxFaultFlag <= faultEvent || (supplyMuxFaultFlag && !clrBits[SUPPLY_FAULT_BIT]);
         settleDoneFlag <= settleEvent || (settleDoneFlag && !clrBits[SETTLE_DONE_BIT]);
      end
   end

   // status word and level interrupt
   logic [15:0] alertStatus;
   assign alertStatus = {13'd0, settleDoneFlag, supplyMuxFaultFlag, resetAlertFlag};
   assign irq = |(alertStatus & alertMask);

   // -----------------------------------------------------------------
   // axi4-lite read path
   // -----------------------------------------------------------------
   logic [15:0] readMux;
   logic readOk;

   // read decode
   // unmapped offsets answer with an error and zero data
   always_comb begin
      readMux = 16'h0000;
      readOk = 1'b1;
      unique case (s_axi_araddr)
         PACK_CFG_OFS: readMux = pack_configuration_reg;
         SCAN_CTRL_OFS: readMux = scanCtrl;
         ALERT_STATUS_OFS: readMux = alertStatus;
         ALERT_MASK_OFS: readMux = alertMask;
         MUX_STATE_OFS: readMux = {6'd0, scanState, muxCtrl.blockTap, muxCtrl.supplyTap};
         default: readOk = 1'b0;
      endcase
   end

   // one read in flight, address refused while data waits
   assign s_axi_arready = !s_axi_rvalid;

   // read data register
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, readMux};
         s_axi_rresp <= readOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* File: pack_mux_properties.sv */
`timescale 1ns/1ns
module pack_mux_properties
   import pack_mux_pkg::*;
(
   // clock and reset
   input logic core_clk,
   input logic rstn,
   // register bus
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [31:0] s_axi_rdata,
   // sequencer and switches
   input logic topConvRequest,
   input logic altPathSelect,
   input logic topConvGo,
   input logic supplyTapSwitchOpen,
   input mux_ctrl_s muxCtrl
);
   // cycles the tap has stood open, for the settle length check
   logic [11:0] openCount;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         openCount <= 12'h000;
      end else begin
         openCount <= supplyTapSwitchOpen ? openCount + 12'h001 : 12'h000;
      end
   end

   // ----------
   // properties
   // ----------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // both write channels handed over at one edge
   sequence bothTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // tap held open with no conversion yet
   sequence noEarlyGo;
      (supplyTapSwitchOpen && !topConvGo) [*8];
   endsequence

   chk_reset_defaults: assert property ($rose(rstn) |-> muxCtrl == {1'b1, TAP_OFF, BLOCK_PIN_CODE})
      else $error("mux control not at defaults during reset");
   chk_tap_range: assert property (muxCtrl.supplyTap >= TAP_MIN_VALID && muxCtrl.blockTap >= TAP_MIN_VALID)
      else $error("unsupported tap code reached the switches");
   chk_go_pulse: assert property (topConvGo |=> !topConvGo)
      else $error("conversion go longer than one cycle");
   chk_fast_go: assert property ((topConvRequest && !altPathSelect && !supplyTapSwitchOpen && !topConvGo) |=>
      topConvGo && !supplyTapSwitchOpen) else $error("primary path request delayed or tap opened");
   chk_settle_hold: assert property ($rose(supplyTapSwitchOpen) |-> noEarlyGo)
      else $error("conversion started before settling");
   chk_settle_time: assert property ($fell(supplyTapSwitchOpen) |-> openCount == SETTLE_CYCLES && topConvGo)
      else $error("settle delay wrong length");
   chk_block_gate: assert property (muxCtrl.blockTap != BLOCK_PIN_CODE |->
      muxCtrl.supplyTap != TAP_OFF && muxCtrl.muxEnable) else $error("block divider moved without valid taps");
   chk_write_resp: assert property (bothTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
endmodule

bind flexible_pack_power_mux_control pack_mux_properties u_pack_mux_properties (.core_clk, .rstn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .topConvRequest, .altPathSelect, .topConvGo,
   .supplyTapSwitchOpen, .muxCtrl);

/* File: flexible_pack_power_mux_control_tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module flexible_pack_power_mux_control_tb;
   import pack_mux_pkg::*;
   // -------
   // signals
   // -------
   logic core_clk = 0, rstn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdVal;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
   logic topConvRequest = 0, altPathSelect = 0, supplyTapSwitchOk = 1;
   logic topConvGo, supplyTapSwitchOpen, irq;
   mux_ctrl_s muxCtrl;
   int fails = 0, samplesChecked = 0;
   typedef struct packed { logic [15:0] cfg; logic [8:0] want; } row_s;
   row_s rows [7] = '{'{16'h39AA, 9'h1A9}, '{16'h38EE, 9'h1E8}, '{16'h30AA, 9'h1AF}, '{16'h3F77, 9'h1FF},
      '{16'h39AB, 9'h1FF}, '{16'h19AA, 9'h1FF}, '{16'h39FF, 9'h1FF}};

   always #10 core_clk = ~core_clk;

   flexible_pack_power_mux_control u_flexible_pack_power_mux_control (.core_clk, .rstn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .topConvRequest, .altPathSelect, .topConvGo, .supplyTapSwitchOk,
      .muxCtrl, .supplyTapSwitchOpen, .irq);

   // -----
   // tasks
   // -----
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bit aw, w;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw && w)) begin
         @(negedge core_clk);
         aw |= s_axi_awvalid && s_axi_awready;
         w |= s_axi_wvalid && s_axi_wready;
         @(posedge core_clk);
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end
      do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
      lastResp = s_axi_bresp;
      @(posedge core_clk);
      s_axi_bready <= 0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(negedge core_clk); while (s_axi_arready !== 1'b1);
      @(posedge core_clk);
      s_axi_arvalid <= 0;
      do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
      rdVal = s_axi_rdata;
      lastResp = s_axi_rresp;
      @(posedge core_clk);
      s_axi_rready <= 0;
      @(posedge core_clk);
   endtask

   // one top-cell request, counts edges until go
   task automatic conv(input logic alt, input int expN, input logic expOpen);
      int n;
      altPathSelect <= alt;
      topConvRequest <= 1;
      @(posedge core_clk);
      topConvRequest <= 0;
      n = 1;
      @(negedge core_clk);
      `CHK(supplyTapSwitchOpen, expOpen)
      while (topConvGo !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         n++;
         @(negedge core_clk);
      end
      `CHK(n, expN)
      @(posedge core_clk);
   endtask

   task automatic doReset();
      rstn <= 0;
      repeat (12) @(posedge core_clk);
      rstn <= 1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic wrap_up();
      if (fails == 0 && samplesChecked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ---------
   // sequences
   // ---------
   initial begin
      doReset();
      `CHK(muxCtrl, 9'h1FF)
      rd(PACK_CFG_OFS);
      `CHK(rdVal, 32'h0000_3FFF)
      rd(ALERT_MASK_OFS);
      `CHK(rdVal, 32'h0000_0000)
      rd(ALERT_STATUS_OFS);
      `CHK(rdVal[RESET_ALERT_BIT], 1'b1)
      `CHK(irq, 1'b0)
      rd(8'h14);
      `CHK({lastResp, rdVal}, {RESP_SLVERR, 32'h0000_0000})
      // configuration table
      foreach (rows[i]) begin
         wr(PACK_CFG_OFS, rows[i].cfg);
         `CHK(lastResp, RESP_OKAY)
         rd(MUX_STATE_OFS);
         `CHK(muxCtrl, rows[i].want)
         `CHK(rdVal, {24'h00_0000, rows[i].want[3:0], rows[i].want[7:4]})
      end
      // fault flag gated until reset alert cleared
      wr(PACK_CFG_OFS, 16'h39AA);
      supplyTapSwitchOk <= 0;
      repeat (4) @(posedge core_clk);
      rd(ALERT_STATUS_OFS);
      `CHK(rdVal[SUPPLY_FAULT_BIT], 1'b0)
      wr(ALERT_STATUS_OFS, 16'h0001);
      rd(ALERT_STATUS_OFS);
      `CHK(rdVal[2:0], 3'b010)
      `CHK(irq, 1'b0)
      supplyTapSwitchOk <= 1;
      wr(ALERT_MASK_OFS, 16'h0002);
      `CHK(irq, 1'b1)
      wr(ALERT_STATUS_OFS, 16'h0002);
      `CHK(irq, 1'b0)
      // acquisitions with and without scan disconnect
      conv(1'b1, 1, 1'b0);
      wr(SCAN_CTRL_OFS, 16'h0001);
      conv(1'b0, 1, 1'b0);
      conv(1'b1, 1501, 1'b1);
      rd(ALERT_STATUS_OFS);
      `CHK(rdVal[SETTLE_DONE_BIT], 1'b1)
      wr(PACK_CFG_OFS, 16'h19AA);
      conv(1'b1, 1, 1'b0);
      // reset in mid-run restores taps and block tap
      wr(PACK_CFG_OFS, 16'h39AA);
      doReset();
      `CHK(muxCtrl, 9'h1FF)
      rd(PACK_CFG_OFS);
      `CHK(rdVal, 32'h0000_3FFF)
      // unaligned offset refused, then a low-lane-only write
      wr(8'h02, 16'h0000);
      `CHK(lastResp, RESP_SLVERR)
      s_axi_wstrb <= 4'h1;
      wr(PACK_CFG_OFS, 16'h0099);
      rd(PACK_CFG_OFS);
      `CHK(rdVal, 32'h0000_3F99)
      wrap_up();
   end

   // watchdog, several times the expected run
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
endmodule
